/* File: sfc_pkg.sv */
// sfc_pkg: opcodes, status layout and timing for the flash command set
// assumes a 250 MHz core clock and a serial clock driven by the host
// Function
// - opcode 06 sets the write enable latch
// - opcode 04 clears the write enable latch
// - opcode 05 shifts out the status byte while selected
// - opcode 01 plus one data byte writes the status register
// - status register write lasts typically 5 ms, at most 40 ms
// - opcode 03 plus address starts a sequential array read
// - opcode 0B plus address starts a fast read after a dummy byte
// - opcode 3B returns array data two bits per clock on both lines
// - opcode 20 plus address erases the sector holding it
// - opcodes 52 and D8 both erase the addressed block
// - opcodes 60 and C7 both erase the whole array
// - opcode 02 plus address and data programs the page
// - opcode B9 enters deep power-down once select is released
// - deep power-down is reached within 10 us of select rising
// - opcode AB leaves deep power-down and returns the signature
// - opcode 9F shifts out the three identification bytes
// - opcode 90 plus address returns maker and device bytes
// - address bit 0 clear gives maker first, set gives device first
// - opcode 2B reads, opcode 2F writes the security register
// - byte program 9 us typical, page program 1.4 ms typical
// - sector erase 60 ms typical, block erase 0.7 s typical
// - whole-array erase 7 s typical before new modifying commands
package sfc_pkg;
  localparam logic [7:0] CMD_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ       = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] CMD_READ              = 8'h03;
  localparam logic [7:0] CMD_FAST_READ         = 8'h0b;
  localparam logic [7:0] CMD_DUAL_READ         = 8'h3b;
  localparam logic [7:0] CMD_SECTOR_WIPE       = 8'h20;
  localparam logic [7:0] CMD_BLOCK_WIPE_A      = 8'h52;
  localparam logic [7:0] CMD_BLOCK_WIPE_B      = 8'hd8;
  localparam logic [7:0] CMD_ARRAY_WIPE_A      = 8'h60;
  localparam logic [7:0] CMD_ARRAY_WIPE_B      = 8'hc7;
  localparam logic [7:0] CMD_PAGE_WRITE        = 8'h02;
  localparam logic [7:0] CMD_SLEEP_ENTRY       = 8'hb9;
  localparam logic [7:0] CMD_SLEEP_EXIT        = 8'hab;
  localparam logic [7:0] CMD_IDENTITY_READ     = 8'h9f;
  localparam logic [7:0] CMD_MAKER_PART_READ   = 8'h90;
  localparam logic [7:0] CMD_SECURE_REG_READ   = 8'h2b;
  localparam logic [7:0] CMD_SECURE_REG_WRITE  = 8'h2f;
  // status byte layout
  localparam int         SR_BUSY_BIT  = 0;
  localparam int         SR_LATCH_BIT = 1;
  localparam logic [7:0] SR_WR_MASK   = 8'h9c;
  localparam logic [7:0] SR_RESET     = 8'h00;
  localparam int         SEC_LOCK_BIT = 1;
  // byte counts at which a frame phase starts
  localparam logic [8:0] N_ADDR_DONE  = 9'h004;
  localparam logic [8:0] N_DUMMY_DONE = 9'h005;
  // identification values, arbitrary
  localparam logic [7:0] ID_MAKER  = 8'h5a;
  localparam logic [7:0] ID_TYPE   = 8'h3c;
  localparam logic [7:0] ID_SIZE   = 8'h14;
  localparam logic [7:0] ID_DEVICE = 8'h13;
  // timing, typical figures except the 10 us deep power-down limit
  localparam int  CLK_MHZ         = 250;
  localparam int  T_STATUS_MS     = 5;
  localparam int  T_BYTE_US       = 9;
  localparam real T_PAGE_MS       = 1.4;
  localparam int  T_SECTOR_MS     = 60;
  localparam real T_BLOCK_S       = 0.7;
  localparam int  T_ARRAY_S       = 7;
  localparam int  T_SLEEP_US      = 10;
  localparam int unsigned SR_CYC  = T_STATUS_MS * 1000 * CLK_MHZ;
  localparam int unsigned BP_CYC  = T_BYTE_US * CLK_MHZ;
  localparam int unsigned PP_CYC  = int'(T_PAGE_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned SE_CYC  = T_SECTOR_MS * 1000 * CLK_MHZ;
  localparam int unsigned BE_CYC  = int'(T_BLOCK_S * 1.0e6 * CLK_MHZ);
  localparam int unsigned CE_CYC  = T_ARRAY_S * 1000000 * CLK_MHZ;
  localparam int unsigned DP_CYC  = T_SLEEP_US * CLK_MHZ;
  localparam int unsigned SYNC_LAT = 3;
  localparam logic [11:0] DP_LOAD = 12'(DP_CYC - SYNC_LAT);
endpackage

/* File: sfc_top.sv */
// sfc_top: serial flash command decoder with internal operation timing
// serial side on i_sclk, select on i_cs_n; core timing on i_clk
`timescale 1ns/1ps
module sfc_top #(
  parameter int          AW     = 8,
  parameter int unsigned SR_CYC = sfc_pkg::SR_CYC,
  parameter int unsigned BP_CYC = sfc_pkg::BP_CYC,
  parameter int unsigned PP_CYC = sfc_pkg::PP_CYC,
  parameter int unsigned SE_CYC = sfc_pkg::SE_CYC,
  parameter int unsigned BE_CYC = sfc_pkg::BE_CYC,
  parameter int unsigned CE_CYC = sfc_pkg::CE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  input  wire logic i_dq0,
  output logic      o_dq0,
  output logic      o_dq0_oe,
  output logic      o_dq1,
  output logic      o_dq1_oe,
  output logic      o_busy,
  output logic      o_sleep,
  output logic      o_wel
);
  localparam int DEPTH = 1 << AW;

  // ---------------- link side ----------------
  logic          link_rst;
  logic [2:0]    bcnt;
  logic [8:0]    nb;
  logic [6:0]    sh;
  logic [7:0]    op_h;
  logic [7:0]    d1_h;
  logic [8:0]    n_h;
  logic [23:0]   addr;
  logic [AW-1:0] ptr;
  logic [7:0]    tx;
  logic          tx_on;
  logic          dual;
  logic [9:0]    st_m;
  logic [9:0]    st_s;
  logic          sl_m;
  logic          sl_s;
  logic          er_m;
  logic          er_s;
  logic          er_d;
  logic [7:0]    mem [DEPTH];
  logic          done;
  logic [7:0]    byte_in;
  logic [7:0]    cur_op;
  logic [8:0]    k;
  logic [23:0]   comb_addr;
  logic [AW-1:0] rd_idx;
  logic [7:0]    next_tx;
  logic          next_send;
  logic          lsb;
  logic          prog_wr;
  logic          wel_s;
  logic          busy_s;

  // ---------------- core side ----------------
  logic        cs_m;
  logic        cs_s;
  logic        cs_d;
  logic        rise;
  logic        wel;
  logic        busy;
  logic [31:0] tmr;
  logic [7:0]  sr_nv;
  logic [1:0]  sec;
  logic        sleep;
  logic [11:0] dp_cnt;
  logic        er_tg;
  logic        mod_ok;
  logic        st_ws;
  logic        st_se;
  logic        st_be;
  logic        st_ce;
  logic        st_pg;
  logic        st_sec;
  logic        st_dp;
  logic [7:0]  status;

  assign link_rst = i_rst | i_cs_n;
  assign byte_in  = {sh, i_dq0};
  assign done     = dual ? (bcnt == 3'h6) : (bcnt == 3'h7);
  assign cur_op   = (nb == 9'h000) ? byte_in : op_h;
  assign k        = nb + 9'h001;
  assign comb_addr = {addr[15:0], byte_in};
  assign rd_idx   = (nb == 9'h003) ? comb_addr[AW-1:0] : ptr;
  assign lsb      = (nb == 9'h003) ? byte_in[0] : addr[0];
  assign wel_s    = st_s[sfc_pkg::SR_LATCH_BIT];
  assign busy_s   = st_s[sfc_pkg::SR_BUSY_BIT];
  assign prog_wr  = done && op_h == sfc_pkg::CMD_PAGE_WRITE &&
                    nb >= 9'h004 && wel_s && !busy_s && !sl_s;

  // core state seen from the serial clock
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      st_m <= 10'h000;
      st_s <= 10'h000;
      sl_m <= 1'b0;
      sl_s <= 1'b0;
      er_m <= 1'b0;
      er_s <= 1'b0;
      er_d <= 1'b0;
    end else begin
      st_m <= {sec, status};
      st_s <= st_m;
      sl_m <= sleep;
      sl_s <= sl_m;
      er_m <= er_tg;
      er_s <= er_m;
      er_d <= er_s;
    end
  end

  // bit and byte counting, cleared while deselected
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      bcnt <= 3'h0;
      nb   <= 9'h000;
      sh   <= 7'h00;
    end else begin
      bcnt <= bcnt + (dual ? 3'h2 : 3'h1);
      sh   <= {sh[5:0], i_dq0};
      if (done && nb != 9'h1ff) begin
        nb <= k;
      end
    end
  end

  // frame record left for the core after select rises
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      op_h <= 8'h00;
      d1_h <= 8'h00;
      n_h  <= 9'h000;
      addr <= 24'h00_0000;
    end else begin
      if (bcnt == 3'h0 && nb == 9'h000) begin
        n_h <= 9'h000;
      end
      if (done) begin
        n_h <= k;
        if (nb == 9'h000) begin
          op_h <= byte_in;
        end
        if (nb == 9'h001) begin
          d1_h <= byte_in;
        end
        if (nb >= 9'h001 && nb <= 9'h003) begin
          addr <= comb_addr;
        end
      end
    end
  end

  // answer byte for the next byte slot
  always_comb begin
    next_tx   = 8'hff;
    next_send = 1'b0;
    case (cur_op)
      sfc_pkg::CMD_STATUS_READ: begin
        next_tx   = st_s[7:0];
        next_send = !sl_s;
      end
      sfc_pkg::CMD_READ: begin
        next_tx   = mem[rd_idx];
        next_send = !sl_s && k >= sfc_pkg::N_ADDR_DONE;
      end
      sfc_pkg::CMD_FAST_READ, sfc_pkg::CMD_DUAL_READ: begin
        next_tx   = mem[rd_idx];
        next_send = !sl_s && k >= sfc_pkg::N_DUMMY_DONE;
      end
      sfc_pkg::CMD_IDENTITY_READ: begin
        case (k % 9'h003)
          9'h001:  next_tx = sfc_pkg::ID_MAKER;
          9'h002:  next_tx = sfc_pkg::ID_TYPE;
          default: next_tx = sfc_pkg::ID_SIZE;
        endcase
        next_send = !sl_s;
      end
      sfc_pkg::CMD_MAKER_PART_READ: begin
        next_tx   = (lsb ^ k[0]) ? sfc_pkg::ID_DEVICE
                                 : sfc_pkg::ID_MAKER;
        next_send = !sl_s && k >= sfc_pkg::N_ADDR_DONE;
      end
      sfc_pkg::CMD_SLEEP_EXIT: begin
        next_tx   = sfc_pkg::ID_DEVICE;
        next_send = k >= sfc_pkg::N_ADDR_DONE;
      end
      sfc_pkg::CMD_SECURE_REG_READ: begin
        next_tx   = {6'h00, st_s[9:8]};
        next_send = !sl_s;
      end
      default: begin
        next_tx   = 8'hff;
        next_send = 1'b0;
      end
    endcase
  end

  // transmit byte, dual phase and array pointer
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      tx    <= 8'hff;
      tx_on <= 1'b0;
      dual  <= 1'b0;
      ptr   <= '0;
    end else if (done) begin
      tx    <= next_tx;
      tx_on <= next_send;
      if (cur_op == sfc_pkg::CMD_DUAL_READ &&
          k >= sfc_pkg::N_DUMMY_DONE) begin
        dual <= 1'b1;
      end
      if (nb == 9'h003) begin
        ptr <= comb_addr[AW-1:0] +
               AW'(cur_op == sfc_pkg::CMD_READ);
      end else if (nb >= 9'h004) begin
        ptr <= ptr + AW'(1);
      end
    end
  end

  // array contents; erase event from the core wipes the window
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'hff;
      end
    end else if (er_s != er_d) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'hff;
      end
    end else if (prog_wr) begin
      mem[ptr] <= mem[ptr] & byte_in;
    end
  end

  // pins change on the falling serial clock
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      o_dq1    <= 1'b0;
      o_dq1_oe <= 1'b0;
      o_dq0    <= 1'b0;
      o_dq0_oe <= 1'b0;
    end else begin
      o_dq1    <= tx[3'h7 - bcnt];
      o_dq1_oe <= tx_on;
      o_dq0    <= tx[3'h6 - bcnt];
      o_dq0_oe <= tx_on && dual;
    end
  end

  // ---------------- core clock ----------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      cs_m <= i_cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
    end
  end

  // frame record is stable while select is high
  assign rise   = cs_s && !cs_d;
  assign mod_ok = rise && !sleep && !busy && wel;
  assign st_ws  = mod_ok && op_h == sfc_pkg::CMD_STATUS_WRITE &&
                  n_h >= 9'h002;
  assign st_se  = mod_ok && op_h == sfc_pkg::CMD_SECTOR_WIPE &&
                  n_h >= sfc_pkg::N_ADDR_DONE;
  assign st_be  = mod_ok && (op_h == sfc_pkg::CMD_BLOCK_WIPE_A ||
                  op_h == sfc_pkg::CMD_BLOCK_WIPE_B) &&
                  n_h >= sfc_pkg::N_ADDR_DONE;
  assign st_ce  = mod_ok && (op_h == sfc_pkg::CMD_ARRAY_WIPE_A ||
                  op_h == sfc_pkg::CMD_ARRAY_WIPE_B) && n_h != 9'h000;
  assign st_pg  = mod_ok && op_h == sfc_pkg::CMD_PAGE_WRITE &&
                  n_h >= sfc_pkg::N_DUMMY_DONE;
  assign st_sec = mod_ok && op_h == sfc_pkg::CMD_SECURE_REG_WRITE &&
                  n_h != 9'h000;
  assign st_dp  = rise && !sleep && !busy && n_h != 9'h000 &&
                  op_h == sfc_pkg::CMD_SLEEP_ENTRY;
  assign status = {sr_nv[7:2], wel, busy};
  assign o_busy = busy;
  assign o_wel  = wel;
  assign o_sleep = sleep;

  // operation timer and busy flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr  <= 32'h0000_0000;
      busy <= 1'b0;
    end else begin
      if (st_ws) begin
        tmr <= SR_CYC;
      end else if (st_pg) begin
        tmr <= (n_h == sfc_pkg::N_DUMMY_DONE) ? BP_CYC : PP_CYC;
      end else if (st_se) begin
        tmr <= SE_CYC;
      end else if (st_be) begin
        tmr <= BE_CYC;
      end else if (st_ce) begin
        tmr <= CE_CYC;
      end else if (tmr != 32'h0000_0000) begin
        tmr <= tmr - 32'h0000_0001;
      end
      if (st_ws || st_pg || st_se || st_be || st_ce) begin
        busy <= 1'b1;
      end else if (tmr == 32'h0000_0001) begin
        busy <= 1'b0;
      end
    end
  end

  // write enable latch
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wel <= 1'b0;
    end else if (busy && tmr == 32'h0000_0001) begin
      wel <= 1'b0;
    end else if (st_sec) begin
      wel <= 1'b0;
    end else if (rise && !sleep && !busy && n_h != 9'h000) begin
      if (op_h == sfc_pkg::CMD_SET_WRITE_LATCH) begin
        wel <= 1'b1;
      end else if (op_h == sfc_pkg::CMD_CLEAR_WRITE_LATCH) begin
        wel <= 1'b0;
      end
    end
  end

  // status and security bits, erase event
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sr_nv <= sfc_pkg::SR_RESET;
      sec   <= 2'h0;
      er_tg <= 1'b0;
    end else begin
      if (st_ws) begin
        sr_nv <= d1_h & sfc_pkg::SR_WR_MASK;
      end
      if (st_sec) begin
        sec[sfc_pkg::SEC_LOCK_BIT] <= 1'b1;
      end
      if (st_se || st_be || st_ce) begin
        er_tg <= !er_tg;
      end
    end
  end

  // deep power-down entry delay and release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dp_cnt <= 12'h000;
      sleep  <= 1'b0;
    end else begin
      if (st_dp) begin
        dp_cnt <= sfc_pkg::DP_LOAD;
      end else if (dp_cnt != 12'h000) begin
        dp_cnt <= dp_cnt - 12'h001;
      end
      if (dp_cnt == 12'h001) begin
        sleep <= 1'b1;
      end else if (rise && sleep && n_h != 9'h000 &&
                   op_h == sfc_pkg::CMD_SLEEP_EXIT) begin
        sleep <= 1'b0;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  wel_set_a:
  assert property (rise && !sleep && !busy && n_h != 9'h000 &&
    op_h == sfc_pkg::CMD_SET_WRITE_LATCH |=> wel)
    else $error("latch not set by enable opcode");
  wel_clr_a:
  assert property (rise && !sleep && !busy && n_h != 9'h000 &&
    op_h == sfc_pkg::CMD_CLEAR_WRITE_LATCH |=> !wel)
    else $error("latch not cleared by disable opcode");
  sr_write_a:
  assert property (st_ws |=> sr_nv == ($past(d1_h) & sfc_pkg::SR_WR_MASK))
    else $error("status write data not stored");
  sr_time_a:
  assert property (st_ws |=> busy && tmr == SR_CYC)
    else $error("status write timer wrong");
  prog_time_a:
  assert property (st_pg && n_h == sfc_pkg::N_DUMMY_DONE
    |=> busy && tmr == BP_CYC)
    else $error("byte program timer wrong");
  wipe_time_a:
  assert property (st_se |=> busy && tmr == SE_CYC)
    else $error("sector erase timer wrong");
  chip_time_a:
  assert property (st_ce |=> busy && tmr == CE_CYC)
    else $error("array erase timer wrong");
  no_latch_a:
  assert property (rise && !wel && !busy |=> !busy)
    else $error("modifying opcode ran without latch");
  end_clear_a:
  assert property ($fell(busy) |-> !wel && tmr == 32'h0000_0000)
    else $error("completion left latch or timer set");
  busy_hold_a:
  assert property (busy && tmr > 32'h0000_0001 |=> busy)
    else $error("busy dropped early");
  sleep_in_a:
  assert property (st_dp |=> dp_cnt == sfc_pkg::DP_LOAD && !sleep)
    else $error("sleep entry count wrong");
  sleep_cnt_a:
  assert property (dp_cnt > 12'h001 && !st_dp
    |=> dp_cnt == $past(dp_cnt) - 12'h001)
    else $error("sleep entry count stalled");
  sleep_set_a:
  assert property (dp_cnt == 12'h001 |=> sleep)
    else $error("sleep not entered after delay");
  wake_a:
  assert property (rise && sleep && n_h != 9'h000 &&
    op_h == sfc_pkg::CMD_SLEEP_EXIT |=> !sleep)
    else $error("release opcode did not wake");
endmodule

/* File: sfc_host.sv */
// sfc_host: host side of the serial link, mode 0, one frame per call
// assumes the bench resolves the shared data lines and calls frame()
`timescale 1ns/1ps
module sfc_host (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso,
  input  wire logic i_dq0
);
  logic [7:0] rx [0:3];

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // ntx bytes out msb first, then nrx bytes in; dual takes two bits a clock
  task automatic frame(input logic [47:0] tx, input int ntx, input int nrx,
                       input bit dual);
    int k;
    #25;  // select high well over 5 core clocks between frames
    o_cs_n = 1'b0;
    #4;
    for (k = 0; k < ntx * 8; k++) begin
      o_mosi = tx[47-k];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    for (k = 0; k < nrx * 8; k += dual ? 2 : 1) begin
      o_mosi = ~o_mosi;  // released input line keeps changing
      #3 o_sclk = 1'b1;
      if (dual)
        rx[k/8] = {rx[k/8][5:0], i_miso, i_dq0};
      else
        rx[k/8] = {rx[k/8][6:0], i_miso};
      #3 o_sclk = 1'b0;
    end
    #3 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask
endmodule

/* File: tb.sv */
// tb: self-checking bench for the flash command decoder
// assumes sfc_pkg, sfc_top and sfc_host are compiled before it
`timescale 1ns/1ps
module tb;
  localparam int BP = 8;
  localparam int PP = 30;
  localparam int SR = 20;
  localparam int SE = 40;
  localparam int BE = 50;
  localparam int CE = 60;
  logic i_clk;
  logic i_rst;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic dq0;
  logic dq0_oe;
  logic dq1;
  logic dq1_oe;
  logic busy;
  logic sleep;
  logic wel;
  logic dq0_w;
  logic miso_w;
  int   errors;
  int   tests_run;

  assign dq0_w  = dq0_oe ? dq0 : mosi;
  assign miso_w = dq1_oe ? dq1 : 1'b1;  // pull-up on the output line

  sfc_top #(.AW(8), .SR_CYC(SR), .BP_CYC(BP), .PP_CYC(PP), .SE_CYC(SE),
            .BE_CYC(BE), .CE_CYC(CE)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_dq0(dq0_w), .o_dq0(dq0), .o_dq0_oe(dq0_oe), .o_dq1(dq1),
    .o_dq1_oe(dq1_oe), .o_busy(busy), .o_sleep(sleep), .o_wel(wel));

  sfc_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
                 .i_miso(miso_w), .i_dq0(dq0_w));

  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;

  task automatic results();
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [7:0] c, input int nrx);
    host.frame({c, 40'h00_0000_0000}, 1, nrx, 1'b0);
  endtask

  task automatic ad(input logic [7:0] c, input logic [23:0] a,
                    input logic [15:0] d, input int ntx, input int nrx,
                    input bit dual);
    host.frame({c, a, d}, ntx, nrx, dual);
  endtask

  task automatic settle();
    repeat (6) @(negedge i_clk);
  endtask

  task automatic busy_len(input int exp);
    int n;
    n = 0;
    repeat (8) if (busy !== 1'b1) @(negedge i_clk);
    while (busy === 1'b1 && n < 1000) begin
      n++;
      @(negedge i_clk);
    end
    chk(n, exp);
    chk(wel, 1'b0);
    if (n == 1000) results();
  endtask

  task automatic t_latch();
    op(8'h05, 1);
    chk(host.rx[0], 8'h00);
    op(8'h06, 0);
    settle();
    chk(wel, 1'b1);
    op(8'h05, 1);
    chk(host.rx[0], 8'h02);
    op(8'h04, 0);
    settle();
    chk(wel, 1'b0);
    ad(8'h02, 24'h00_0005, 16'h1200, 5, 0, 1'b0);
    settle();
    chk(busy, 1'b0);
  endtask

  task automatic t_prog();
    op(8'h06, 0);
    ad(8'h02, 24'h00_0005, 16'ha53c, 6, 0, 1'b0);
    busy_len(PP);
    op(8'h06, 0);
    ad(8'h02, 24'h00_0009, 16'h7e00, 5, 0, 1'b0);
    busy_len(BP);
    ad(8'h03, 24'h00_0005, 16'h0000, 4, 2, 1'b0);
    chk({host.rx[0], host.rx[1]}, 16'ha53c);
    ad(8'h03, 24'h00_0009, 16'h0000, 4, 2, 1'b0);
    chk({host.rx[0], host.rx[1]}, 16'h7eff);
    ad(8'h0b, 24'h00_0005, 16'h0000, 5, 1, 1'b0);
    chk(host.rx[0], 8'ha5);
    ad(8'h3b, 24'h00_0005, 16'h0000, 5, 2, 1'b1);
    chk({host.rx[0], host.rx[1]}, 16'ha53c);
  endtask

  task automatic t_erase();
    logic [7:0] c [0:4] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    int         nb [0:4] = '{4, 4, 4, 1, 1};
    int         len [0:4] = '{SE, BE, BE, CE, CE};
    for (int i = 0; i < 5; i++) begin
      op(8'h06, 0);
      ad(c[i], 24'h00_0005, 16'h0000, nb[i], 0, 1'b0);
      busy_len(len[i]);
      if (i == 0) begin
        ad(8'h03, 24'h00_0005, 16'h0000, 4, 1, 1'b0);
        chk(host.rx[0], 8'hff);
      end
    end
    op(8'h06, 0);
    op(8'hc7, 0);
    op(8'h05, 1);
    chk(host.rx[0], 8'h03);
    repeat (CE) @(negedge i_clk);
    chk(busy, 1'b0);
    chk(wel, 1'b0);
  endtask

  task automatic t_ident();
    op(8'h9f, 3);
    chk(host.rx[0], sfc_pkg::ID_MAKER);
    chk({host.rx[1], host.rx[2]}, {sfc_pkg::ID_TYPE, sfc_pkg::ID_SIZE});
    ad(8'h90, 24'h00_0000, 16'h0000, 4, 2, 1'b0);
    chk({host.rx[0], host.rx[1]}, {sfc_pkg::ID_MAKER, sfc_pkg::ID_DEVICE});
    ad(8'h90, 24'h00_0001, 16'h0000, 4, 2, 1'b0);
    chk({host.rx[0], host.rx[1]}, {sfc_pkg::ID_DEVICE, sfc_pkg::ID_MAKER});
    ad(8'hab, 24'h00_0000, 16'h0000, 4, 1, 1'b0);
    chk(host.rx[0], sfc_pkg::ID_DEVICE);
  endtask

  task automatic t_regs();
    op(8'h06, 0);
    op(8'h2f, 0);
    settle();
    op(8'h2b, 1);
    chk(host.rx[0], 8'h02);
    op(8'h06, 0);
    ad(8'h01, 24'hff_0000, 16'h0000, 2, 0, 1'b0);
    busy_len(SR);
    op(8'h05, 1);
    chk(host.rx[0], 8'h9c);
  endtask

  task automatic t_sleep();
    int n;
    n = 0;
    op(8'hb9, 0);
    // count in ns from select rising, so clock phase adds no slack
    while (sleep !== 1'b1 && n < 12000) begin
      n++;
      #1;
    end
    chk(n <= 10000, 1'b1);
    if (n == 12000) results();
    op(8'h9f, 1);
    chk(host.rx[0], 8'hff);
    ad(8'hab, 24'h00_0000, 16'h0000, 4, 1, 1'b0);
    chk(host.rx[0], sfc_pkg::ID_DEVICE);
    settle();
    chk(sleep, 1'b0);
  endtask

  initial begin
    i_rst = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk({busy, sleep, wel}, 3'b000);
    t_latch();
    t_prog();
    t_erase();
    t_ident();
    t_regs();
    t_sleep();
    results();
  end
endmodule
